/* hdl/dcc_cmd_handler.sv */
// Purpose: parses ~ commands 4, 5, D, E and sends ! or ? replies with the module address
// Assumes: rx bytes come from logic on sys_clk_i; tx_ready_i is from the transmitter on this clock
// Notes: storage is flip-flops standing in for retained memory; reset loads defaults
// Notes on behaviour
// - mask-set frame is tilde, address, 5, power-on mask, safe mask, CR.
// - power-on mask bit n belongs to output channel n, 1 means active.
// - safe mask bit n belongs to output channel n, 1 means active.
// - accepted command replies with !, address, data, then CR.
// - well-formed but unperformable command replies with ?, address, CR.
// - bad syntax, comm error or foreign address gets no reply at all.
// - masks never act on outputs assigned to alarm functions.
// - D with no parameter returns the polarity byte as two hex digits.
// - D with two hex digits stores the polarity byte and acknowledges.
// - polarity bit 0 inverts the raw input sense when set.
// - polarity bit 1 makes output value 0 the active level when set.
// - E0 disables and E1 enables calibration mode, then acknowledge.
// - other calibration commands raise cal_reject_o until calibration mode is enabled; E with any digit but 0 or 1 gets ?.
// - reply address is two hex characters, any value 00 to FF.
// - 4 with no parameter returns power-on mask then safe mask.
module dcc_cmd_handler #(
    parameter int NUM_DO = 8,
    parameter int NUM_DI = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] module_address_field_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic rx_error_i,
    input wire logic cal_cmd_i,
    input wire logic safe_mode_i,
    input wire logic [NUM_DO-1:0] alarm_map_i,
    input wire logic [NUM_DO-1:0] alarm_out_i,
    input wire logic [NUM_DO-1:0] do_value_i,
    input wire logic [NUM_DI-1:0] di_raw_i,
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    output logic cal_reject_o,
    output logic [7:0] power_on_mask_o,
    output logic [7:0] safe_mask_o,
    output logic [7:0] polarity_settings_byte_o,
    output logic cal_enable_o,
    output logic [NUM_DO-1:0] do_pin_o,
    output logic [NUM_DI-1:0] di_active_o
);
    import dcc_pkg::*;
    `include "dcc_defines.svh"

    // receive buffer: chars after the tilde, before CR
    logic [7:0] buf_q [0:8];
    logic [3:0] cnt, next_cnt;
    logic in_frame, next_in_frame, bad, next_bad;
    logic [7:0] pom, next_pom, sfm, next_sfm, pol, next_pol;
    logic cal_en, next_cal_en, cal_rej, next_cal_rej;
    logic [NUM_DO-1:0] do_pin, next_do_pin;
    logic [NUM_DI-1:0] di_act, next_di_act;
    logic power_up, next_power_up;
    dcc_state_type st, next_st;
    logic lead_ok, next_lead_ok;
    logic [7:0] rep [0:3];
    logic [7:0] next_rep [0:3];
    logic [2:0] rlen, next_rlen, ridx, next_ridx;
    logic addr_hi_sel, next_addr_hi_sel;
    logic [7:0] tx_data, next_tx_data;
    logic tx_valid, next_tx_valid;

    // decode of six buffered positions; every mask digit gets a full hex check
    logic [3:0] nib [0:5];
    logic nok [0:5];
    logic [7:0] enc [0:5];
    logic [3:0] enc_in [0:5];
    logic [7:0] rx_buf_in [0:5];

    assign rx_buf_in[0] = buf_q[0];
    assign rx_buf_in[1] = buf_q[1];
    assign rx_buf_in[2] = buf_q[3];
    assign rx_buf_in[3] = buf_q[4];
    assign rx_buf_in[4] = buf_q[5];
    assign rx_buf_in[5] = buf_q[6];
    // encoders: addr hi/lo, polarity byte hi/lo, two spares
    assign enc_in[0] = module_address_field_i[7:4];
    assign enc_in[1] = module_address_field_i[3:0];
    assign enc_in[2] = pol[7:4];
    assign enc_in[3] = pol[3:0];
    assign enc_in[4] = 4'h0;
    assign enc_in[5] = 4'h0;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_hex
            dcc_hex_nib u_hex (
                .ch_i(rx_buf_in[g]),
                .nib_o(nib[g]),
                .ok_o(nok[g]),
                .enc_i(enc_in[g]),
                .ch_enc_o(enc[g])
            );
        end
    endgenerate

    function automatic logic [7:0] hexc(input logic [3:0] n);
        hexc = (n < 4'hA) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
    endfunction

    logic [7:0] frame_addr;
    assign frame_addr = {nib[0], nib[1]};

    always_comb begin
        next_cnt = cnt;
        next_in_frame = in_frame;
        next_bad = bad;
        next_pom = pom;
        next_sfm = sfm;
        next_pol = pol;
        next_cal_en = cal_en;
        next_cal_rej = 1'b0;
        next_lead_ok = lead_ok;
        next_rlen = rlen;
        next_st = st;
        for (int i = 0; i < 4; i++) begin
            next_rep[i] = rep[i];
        end
        // calibration commands decoded elsewhere are refused while disabled
        if (cal_cmd_i && !cal_en) begin
            next_cal_rej = 1'b1;
        end
        if (rx_valid_i && st == DCC_IDLE) begin
            if (rx_data_i == `DCC_CH_TILDE) begin
                next_in_frame = 1'b1;
                next_cnt = 4'h0;
                next_bad = rx_error_i;
            end else if (in_frame && rx_data_i == `DCC_CH_CR) begin
                next_in_frame = 1'b0;
                // silent on errors, bad digits or another address
                if (!bad && !rx_error_i && cnt >= `DCC_LEN_QUERY && nok[0] && nok[1]
                        && frame_addr == module_address_field_i) begin
                    next_lead_ok = 1'b1;
                    next_rlen = 3'h0;
                    next_st = DCC_LEAD;
                    case (buf_q[2])
                        `DCC_FN_MASK_RD: begin
                            if (cnt == `DCC_LEN_QUERY) begin
                                next_rep[0] = hexc(pom[7:4]);
                                next_rep[1] = hexc(pom[3:0]);
                                next_rep[2] = hexc(sfm[7:4]);
                                next_rep[3] = hexc(sfm[3:0]);
                                next_rlen = 3'h4;
                            end else begin
                                next_st = DCC_IDLE;
                            end
                        end
                        `DCC_FN_MASK_WR: begin
                            if (cnt == `DCC_LEN_MASK_SET && nok[2] && nok[3] && nok[4]
                                    && nok[5]) begin
                                next_pom = {nib[2], nib[3]};
                                next_sfm = {nib[4], nib[5]};
                            end else begin
                                next_st = DCC_IDLE;
                            end
                        end
                        `DCC_FN_POL: begin
                            if (cnt == `DCC_LEN_QUERY) begin
                                next_rep[0] = enc[2];
                                next_rep[1] = enc[3];
                                next_rlen = 3'h2;
                            end else if (cnt == `DCC_LEN_POL_SET && nok[2] && nok[3]) begin
                                next_pol = {nib[2], nib[3]};
                            end else begin
                                next_st = DCC_IDLE;
                            end
                        end
                        `DCC_FN_CAL: begin
                            if (cnt == `DCC_LEN_CAL_SET && buf_q[3] == `DCC_DIG_0) begin
                                next_cal_en = 1'b0;
                            end else if (cnt == `DCC_LEN_CAL_SET && buf_q[3] == `DCC_DIG_1) begin
                                next_cal_en = 1'b1;
                            end else if (cnt == `DCC_LEN_CAL_SET) begin
                                next_lead_ok = 1'b0;
                            end else begin
                                next_st = DCC_IDLE;
                            end
                        end
                        default: next_st = DCC_IDLE;
                    endcase
                end
            end else if (in_frame) begin
                if (cnt == `DCC_MAX_CHARS) begin
                    next_bad = 1'b1;
                end else begin
                    next_cnt = 4'(cnt + 4'h1);
                end
                if (rx_error_i) begin
                    next_bad = 1'b1;
                end
            end
        end
        // transmit walk
        next_ridx = ridx;
        next_addr_hi_sel = addr_hi_sel;
        next_tx_data = tx_data;
        next_tx_valid = tx_valid;
        if (tx_valid && tx_ready_i) begin
            next_tx_valid = 1'b0;
        end
        if (!tx_valid || tx_ready_i) begin
            case (st)
                DCC_IDLE: ;
                DCC_LEAD: begin
                    next_tx_data = lead_ok ? `DCC_CH_BANG : `DCC_CH_QUEST;
                    next_tx_valid = 1'b1;
                    next_addr_hi_sel = 1'b1;
                    next_st = DCC_ADDR;
                end
                DCC_ADDR: begin
                    next_tx_data = addr_hi_sel ? enc[0] : enc[1];
                    next_tx_valid = 1'b1;
                    next_addr_hi_sel = 1'b0;
                    next_ridx = 3'h0;
                    if (!addr_hi_sel) begin
                        next_st = (lead_ok && rlen != 3'h0) ? DCC_DATA : DCC_TERM;
                    end
                end
                DCC_DATA: begin
                    next_tx_data = rep[ridx[1:0]];
                    next_tx_valid = 1'b1;
                    next_ridx = 3'(ridx + 3'h1);
                    if (3'(ridx + 3'h1) == rlen) begin
                        next_st = DCC_TERM;
                    end
                end
                DCC_TERM: begin
                    next_tx_data = `DCC_CH_CR;
                    next_tx_valid = 1'b1;
                    next_st = DCC_IDLE;
                end
                default: next_st = DCC_IDLE;
            endcase
        end
        // output stage: safe mask in safe mode, power-on mask right after reset
        next_power_up = 1'b0;
        for (int i = 0; i < NUM_DO; i++) begin
            logic act;
            act = do_value_i[i];
            if (i < 8) begin
                if (power_up) begin
                    act = pom[i];
                end else if (safe_mode_i) begin
                    act = sfm[i];
                end
            end
            if (alarm_map_i[i]) begin
                act = alarm_out_i[i];
            end
            next_do_pin[i] = act ^ pol[`DCC_POL_OUT_BIT];
        end
        for (int i = 0; i < NUM_DI; i++) begin
            next_di_act[i] = di_raw_i[i] ^ pol[`DCC_POL_IN_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 4'h0;
            in_frame <= 1'b0;
            bad <= 1'b0;
            pom <= `DCC_RESET_MASK;
            sfm <= `DCC_RESET_MASK;
            pol <= `DCC_RESET_POL;
            cal_en <= 1'b0;
            cal_rej <= 1'b0;
            lead_ok <= 1'b0;
            rlen <= 3'h0;
            ridx <= 3'h0;
            st <= DCC_IDLE;
            addr_hi_sel <= 1'b0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            do_pin <= '0;
            di_act <= '0;
            power_up <= 1'b1;
            for (int i = 0; i < 9; i++) begin
                buf_q[i] <= 8'h00;
            end
            for (int i = 0; i < 4; i++) begin
                rep[i] <= 8'h00;
            end
        end else begin
            cnt <= next_cnt;
            in_frame <= next_in_frame;
            bad <= next_bad;
            pom <= next_pom;
            sfm <= next_sfm;
            pol <= next_pol;
            cal_en <= next_cal_en;
            cal_rej <= next_cal_rej;
            lead_ok <= next_lead_ok;
            rlen <= next_rlen;
            ridx <= next_ridx;
            st <= next_st;
            addr_hi_sel <= next_addr_hi_sel;
            tx_data <= next_tx_data;
            tx_valid <= next_tx_valid;
            do_pin <= next_do_pin;
            di_act <= next_di_act;
            power_up <= next_power_up;
            if (rx_valid_i && st == DCC_IDLE && in_frame && rx_data_i != `DCC_CH_CR
                    && rx_data_i != `DCC_CH_TILDE && cnt < `DCC_MAX_CHARS) begin
                buf_q[cnt] <= rx_data_i;
            end
            for (int i = 0; i < 4; i++) begin
                rep[i] <= next_rep[i];
            end
        end
    end

    assign tx_data_o = tx_data;
    assign tx_valid_o = tx_valid;
    assign cal_reject_o = cal_rej;
    assign power_on_mask_o = pom;
    assign safe_mask_o = sfm;
    assign polarity_settings_byte_o = pol;
    assign cal_enable_o = cal_en;
    assign do_pin_o = do_pin;
    assign di_active_o = di_act;

    a_reply_lead: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st == DCC_LEAD && !tx_valid) |=> tx_valid && (tx_data == `DCC_CH_BANG || tx_data == `DCC_CH_QUEST))
        else $error("reply lead char wrong");
    a_cal_gate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (cal_cmd_i && !cal_en) |=> cal_rej) else $error("cal command not refused");
    a_cal_pass: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (cal_cmd_i && cal_en) |=> !cal_rej) else $error("cal refused while enabled");
    a_di_sense: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ##1 di_act == ($past(di_raw_i) ^ {NUM_DI{$past(pol[0])}})) else $error("input sense wrong");
    // every alarm channel, not just one, so the check sees the channels the bench really maps
    a_alarm_keep: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (|alarm_map_i) |=> ((do_pin ^ {NUM_DO{$past(pol[1])}}) & $past(alarm_map_i))
            == ($past(alarm_out_i) & $past(alarm_map_i)))
        else $error("mask touched alarm channel");
    a_safe_out: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (safe_mode_i && !power_up && !alarm_map_i[0]) |=> do_pin[0] == ($past(sfm[0]) ^ $past(pol[1])))
        else $error("safe mask not applied");
    a_silent_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st == DCC_IDLE && !tx_valid) |=> !tx_valid) else $error("reply without frame");
    a_reply_end: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st == DCC_TERM && (!tx_valid || tx_ready_i)) |=> tx_data == `DCC_CH_CR && st == DCC_IDLE)
        else $error("reply not ended by CR");
    c_ack: cover property (@(posedge sys_clk_i) tx_valid && tx_data == `DCC_CH_BANG);
    c_nak: cover property (@(posedge sys_clk_i) tx_valid && tx_data == `DCC_CH_QUEST);
    c_cal_on: cover property (@(posedge sys_clk_i) $rose(cal_en));
    c_data: cover property (@(posedge sys_clk_i) st == DCC_DATA);
endmodule

/* hdl/dcc_defines.svh */
// Purpose: constants for the digital output config and calibration command handler
// Assumes: ascii characters arrive one per valid strobe from an external receiver
// Notes: checksum handling lies outside; frames here carry no checksum
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_CH_TILDE 8'h7E
`define DCC_CH_CR 8'h0D
`define DCC_CH_BANG 8'h21
`define DCC_CH_QUEST 8'h3F
`define DCC_FN_MASK_RD 8'h34
`define DCC_FN_MASK_WR 8'h35
`define DCC_FN_POL 8'h44
`define DCC_FN_CAL 8'h45
`define DCC_DIG_0 8'h30
`define DCC_DIG_1 8'h31
`define DCC_MAX_CHARS 4'h9
`define DCC_LEN_QUERY 4'h3
`define DCC_LEN_MASK_SET 4'h7
`define DCC_LEN_POL_SET 4'h5
`define DCC_LEN_CAL_SET 4'h4
`define DCC_POL_IN_BIT 0
`define DCC_POL_OUT_BIT 1
`define DCC_RESET_MASK 8'h00
`define DCC_RESET_POL 8'h00
`endif

/* hdl/dcc_hex_nib.sv */
// Purpose: one ascii hex digit to nibble, and nibble to ascii hex digit
// Assumes: upper or lower case digits accepted on decode
// Notes: encode always yields upper case
module dcc_hex_nib (
    input wire logic [7:0] ch_i,
    output logic [3:0] nib_o,
    output logic ok_o,
    input wire logic [3:0] enc_i,
    output logic [7:0] ch_enc_o
);
    always_comb begin
        ok_o = 1'b1;
        nib_o = 4'h0;
        if (ch_i >= 8'h30 && ch_i <= 8'h39) begin
            nib_o = ch_i[3:0];
        end else if ((ch_i >= 8'h41 && ch_i <= 8'h46) || (ch_i >= 8'h61 && ch_i <= 8'h66)) begin
            nib_o = 4'(ch_i[3:0] + 4'h9);
        end else begin
            ok_o = 1'b0;
        end
        if (enc_i < 4'hA) begin
            ch_enc_o = {4'h3, enc_i};
        end else begin
            ch_enc_o = {4'h4, 4'(enc_i - 4'h9)};
        end
    end
endmodule

/* hdl/dcc_pkg.sv */
// Purpose: types for the command handler
// Assumes: nothing
// Notes: reply states are gray coded from DCC_IDLE through DCC_LEAD, DCC_ADDR and DCC_DATA to DCC_TERM
package dcc_pkg;
    typedef enum logic [2:0] {
        DCC_IDLE = 3'h0,
        DCC_LEAD = 3'h1,
        DCC_ADDR = 3'h3,
        DCC_DATA = 3'h2,
        DCC_TERM = 3'h6
    } dcc_state_type;
endpackage

/* tb/dcc_host_model.sv */
// Purpose: host on the shared ascii bus, sends command frames and collects reply characters
// Assumes: frames carry no checksum; one character strobe at a time with a gap cycle
// Notes: slow mode accepts reply characters only every other cycle
module dcc_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_error_o,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic slow = 1'b0;
    logic [7:0] reply_q[$];
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        rx_error_o = 1'b0;
        tx_ready_o = 1'b1;
    end
    // reply byte is taken at the edge where ready is seen high
    always @(posedge sys_clk_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o) begin
            reply_q.push_back(tx_data_i);
        end
        #1;
        tx_ready_o = slow ? ~tx_ready_o : 1'b1;
    end
    // frame is sent whole, cr appended; idle data line toggles so stale bytes never look valid
    task automatic send_frame(input string s, input int err_at);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge sys_clk_i);
            #1;
            rx_data_o = (i == s.len()) ? 8'h0D : s[i];
            rx_valid_o = 1'b1;
            rx_error_o = (i == err_at);
            @(posedge sys_clk_i);
            #1;
            rx_valid_o = 1'b0;
            rx_error_o = 1'b0;
            rx_data_o = ~rx_data_o;
        end
    endtask
endmodule

/* tb/test_dio_config_calib_command_handler.sv */
// Purpose: self-checking bench for the command handler
// Assumes: host model answers promptly or slowly; address 01 unless a scenario moves it
// Notes: register outputs except cal_reject are checked at least two cycles after their cause to let them settle
module test_dio_config_calib_command_handler;
    timeunit 1ns;
    timeprecision 100ps;
    import dcc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr = 8'h01;
    logic [7:0] rx_data;
    logic rx_valid, rx_error, tx_ready, tx_valid, cal_reject, cal_enable;
    logic cal_cmd = 1'b0;
    logic safe_mode = 1'b0;
    logic [7:0] alarm_map = 8'h00;
    logic [7:0] alarm_out = 8'h00;
    logic [7:0] do_value = 8'h00;
    logic [7:0] di_raw = 8'h00;
    logic [7:0] tx_data, pom, sfm, pol, do_pin, di_act;
    int num_errors = 0;
    int n_tests = 0;
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    dcc_cmd_handler #(.NUM_DO(8), .NUM_DI(8)) dut_u (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .module_address_field_i(addr),
        .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_error_i(rx_error), .cal_cmd_i(cal_cmd),
        .safe_mode_i(safe_mode), .alarm_map_i(alarm_map), .alarm_out_i(alarm_out),
        .do_value_i(do_value), .di_raw_i(di_raw), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .cal_reject_o(cal_reject), .power_on_mask_o(pom), .safe_mask_o(sfm),
        .polarity_settings_byte_o(pol), .cal_enable_o(cal_enable), .do_pin_o(do_pin),
        .di_active_o(di_act)
    );
    dcc_host_model host_u (
        .sys_clk_i(sys_clk_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .rx_error_o(rx_error), .tx_ready_o(tx_ready)
    );
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    // waits for the whole reply plus cr, then makes sure nothing trails it
    task automatic expect_reply(input string s);
        int n;
        n = 0;
        while (host_u.reply_q.size() < s.len() + 1 && n < 400) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (host_u.reply_q.size() < s.len() + 1) begin
            num_errors++;
            $display("Error at %0t: reply timeout", $time);
            stop_test();
        end else begin
            for (int i = 0; i < s.len(); i++) begin
                check(host_u.reply_q[i], s[i]);
            end
            check(host_u.reply_q[s.len()], 8'h0D);
            repeat (6) @(posedge sys_clk_i);
            #1;
            check(8'(host_u.reply_q.size()), 8'(s.len() + 1));
            host_u.reply_q.delete();
        end
    endtask
    task automatic expect_silence;
        repeat (30) @(posedge sys_clk_i);
        #1;
        check(8'(host_u.reply_q.size()), 8'h00);
        host_u.reply_q.delete();
    endtask
    task automatic t_reset;
        #1;
        check(pom, 8'h00);
        check(sfm, 8'h00);
        check(pol, 8'h00);
        check({7'h00, cal_enable}, 8'h00);
    endtask
    task automatic t_masks;
        host_u.send_frame("~0150106", -1);
        expect_reply("!01");
        check(pom, 8'h01);
        check(sfm, 8'h06);
        host_u.slow = 1'b1;
        host_u.send_frame("~014", -1);
        expect_reply("!010106");
        host_u.slow = 1'b0;
        addr = 8'hAF;
        host_u.send_frame("~af4", -1);
        expect_reply("!AF0106");
        addr = 8'h01;
    endtask
    task automatic t_silent;
        host_u.send_frame("~024", -1);
        expect_silence();
        host_u.send_frame("~014", 2);
        expect_silence();
        host_u.send_frame("~0G4", -1);
        expect_silence();
        host_u.send_frame("~01Z", -1);
        expect_silence();
        host_u.send_frame("~014", -1);
        expect_reply("!010106");
    endtask
    task automatic t_polarity;
        do_value = 8'h5A;
        di_raw = 8'h3C;
        host_u.send_frame("~01D03", -1);
        expect_reply("!01");
        check(pol, 8'h03);
        host_u.send_frame("~01D", -1);
        expect_reply("!0103");
        check(di_act, 8'hC3);
        check(do_pin, 8'hA5);
        host_u.send_frame("~01D00", -1);
        expect_reply("!01");
        settle();
        check(di_act, 8'h3C);
        check(do_pin, 8'h5A);
    endtask
    // alarm channel 2 must follow its alarm value even though the safe mask sets it
    task automatic t_safe;
        alarm_map = 8'h04;
        alarm_out = 8'h00;
        safe_mode = 1'b1;
        settle();
        check(do_pin, 8'h02);
        alarm_out = 8'h04;
        settle();
        check(do_pin, 8'h06);
        safe_mode = 1'b0;
        settle();
        check(do_pin, 8'h5E);
        alarm_map = 8'h00;
    endtask
    task automatic cal_pulse(input logic exp_reject);
        @(posedge sys_clk_i);
        #1;
        cal_cmd = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cal_cmd = 1'b0;
        check({7'h00, cal_reject}, {7'h00, exp_reject});
    endtask
    task automatic t_cal;
        cal_pulse(1'b1);
        host_u.send_frame("~01E1", -1);
        expect_reply("!01");
        check({7'h00, cal_enable}, 8'h01);
        cal_pulse(1'b0);
        host_u.send_frame("~01E2", -1);
        expect_reply("?01");
        host_u.send_frame("~01E0", -1);
        expect_reply("!01");
        check({7'h00, cal_enable}, 8'h00);
        cal_pulse(1'b1);
    endtask
    initial begin
        #2000000;
        num_errors++;
        $display("Error at %0t: run timeout", $time);
        stop_test();
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        #1;
        reset_n_i = 1'b1;
        t_reset();
        t_masks();
        t_silent();
        t_polarity();
        t_safe();
        t_cal();
        stop_test();
    end
endmodule
